// >>> hdl/brc_pkg.sv
// Constants, encodings and state codes for the brown-out and reset sequencer.
// Assumes a 25 MHz pclk; times are converted to cycles here for the top module to use.
package brc_pkg;
  // Register byte offsets on the APB bus.
  localparam logic [7:0] BRC_CFG_OFS  = 8'h00;
  localparam logic [7:0] BRC_CTRL_OFS = 8'h04;
  localparam logic [7:0] BRC_STAT_OFS = 8'h08;
  // Configuration register fields.
  localparam int BRC_CFG_MODE_LSB  = 0;
  localparam int BRC_CFG_LEVEL_LSB = 2;
  localparam int BRC_CFG_POWER_UP_DELAY_TIMER_LSB  = 4;
  // Control and status register fields.
  localparam int BRC_CTRL_SWEN_BIT   = 0;
  localparam int BRC_STAT_RDY_BIT    = 0;
  localparam int BRC_STAT_FLAGN_BIT  = 1;
  localparam int BRC_STAT_RUN_BIT    = 2;
  localparam int BRC_STAT_RSTN_BIT   = 3;
  localparam int BRC_STAT_BELOW_BIT  = 4;
  // Reset values.
  localparam logic [1:0] BRC_MODE_RST  = 2'h3;
  localparam logic [1:0] BRC_LEVEL_RST = 2'h0;
  localparam logic [1:0] BRC_POWER_UP_DELAY_TIMER_RST  = 2'h3;
  localparam logic       BRC_SWEN_RST  = 1'b1;
  // Brown-out operating modes.
  localparam logic [1:0] BRC_MODE_OFF     = 2'h0;
  localparam logic [1:0] BRC_MODE_SW      = 2'h1;
  localparam logic [1:0] BRC_MODE_NOSLEEP = 2'h2;
  localparam logic [1:0] BRC_MODE_ON      = 2'h3;
  localparam logic [1:0] BRC_POWER_UP_DELAY_TIMER_OFF     = 2'h0;
  // Timing.
  localparam int BRC_CLK_NS    = 40;
  localparam int BRC_POWER_UP_DELAY_TIMER_MS   = 64;
  localparam int BRC_POWER_UP_DELAY_TIMER_CYC  = BRC_POWER_UP_DELAY_TIMER_MS * 1000000 / BRC_CLK_NS;
  localparam int BRC_FILT_NS   = 1000;
  localparam int BRC_FILT_CYC  = (BRC_FILT_NS + BRC_CLK_NS - 1) / BRC_CLK_NS;
  localparam int BRC_FILT_W    = 8;
  localparam int BRC_START_CYC = 10;
  localparam int BRC_NUM_LEVELS = 4;

  typedef enum logic [6:0] {
    BRC_ST_HOLD  = 7'h01,
    BRC_ST_POWER_UP_DELAY_TIMER  = 7'h02,
    BRC_ST_CLR   = 7'h04,
    BRC_ST_START = 7'h08,
    BRC_ST_RUN   = 7'h10,
    BRC_ST_SLEEP = 7'h20,
    BRC_ST_WAKE  = 7'h40
  } brc_state_t;
endpackage : brc_pkg

// >>> hdl/brc_sync2.sv
// Two-stage synchroniser for a vector of asynchronous levels.
// Assumes each bit is an independent level; no bus coherency is implied.
`timescale 1ns/1ns
module brc_sync2 #(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Levels.
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } brc_sync_t;

  brc_sync_t r;
  brc_sync_t r_nxt;

  always_comb begin
    r_nxt    = r;
    r_nxt.s1 = d;
    r_nxt.s2 = r.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  assign q = r.s2;
endmodule : brc_sync2

// >>> hdl/brc_top.sv
// Reset source aggregation, brown-out mode control and start-up sequencing.
// Assumes synchronous digital inputs, asynchronous analog detector levels.
// Function
// RULE1: Any of power-on, brown-out, clear pin, watchdog, instruction, stack, programming resets.
// RULE2: Enabled power-up timer lengthens reset after power-on or brown-out.
// RULE3: Hold reset while supply is below power-on level.
// RULE4: Programming mode exit behaves exactly like a fresh power-on.
// RULE5: Level select picks trip level; reset held while supply is below it.
// RULE6: Only dips longer than the filter time reset and clear the cause flag.
// RULE7: Mode 11 keeps detector on; start-up waits for ready and good supply.
// RULE8: Mode 11 protects in sleep; wake-up does not wait on detector.
// RULE9: Mode 10 detector sleeps with core; wake-up waits ready and good supply.
// RULE10: Mode 01 detector follows the software enable bit.
// RULE11: Mode 01 start-up is not gated by readiness or supply.
// RULE12: Protection acts once detector ready; readiness readable as status bit.
// RULE13: Mode 01 sleep does not change the software-selected protection.
// RULE14: Mode 00 disables detection, ignores enable writes, starts immediately.
// RULE15: Mode 11 ready flag reads one before first instruction.
// RULE16: Power-up delay inserted only when delay select is not 00.
// RULE17: Power-up timer up to 64 ms, starts on release, holds reset.
// RULE18: Execution starts 10 cycles after delay done and clear pin released.
// RULE19: Analog detector outputs are synchronised before use.
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ns
module brc_top
  import brc_pkg::*;
#(
  parameter int POWER_UP_DELAY_TIMER_CYC = brc_pkg::BRC_POWER_UP_DELAY_TIMER_CYC,
  parameter int NLVL     = brc_pkg::BRC_NUM_LEVELS
) (
  // Clock and reset.
  input  wire logic            pclk,
  input  wire logic            presetn,
  // APB slave.
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  // Analog detectors, asynchronous.
  input  wire logic            por_ok_a,
  input  wire logic [NLVL-1:0] bor_below_a,
  input  wire logic            bor_rdy_a,
  // Reset sources and core status.
  input  wire logic            ext_clear_pin_n,
  input  wire logic            ext_clear_en,
  input  wire logic            wdt_timeout,
  input  wire logic            reset_instr,
  input  wire logic            stack_ovf,
  input  wire logic            stack_unf,
  input  wire logic            prog_mode,
  input  wire logic            sleep_mode,
  input  wire logic            wake_req,
  // Core controls.
  output logic                 cpu_reset_n,
  output logic                 cpu_run,
  output logic                 bor_det_en
);
  import brc_pkg::*;

  localparam int PW = $clog2(POWER_UP_DELAY_TIMER_CYC + 1);
  localparam int LW = (NLVL > 1) ? $clog2(NLVL) : 1;

  typedef struct packed {
    brc_state_t            st;
    logic [PW-1:0]         cnt;
    logic [BRC_FILT_W-1:0] filt;
    logic [1:0]            mode;
    logic [1:0]            lvl;
    logic [1:0]            powerup_delay_sel;
    logic                  sw_en;
    logic                  flag_n;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  rst_n;
    logic                  run;
    logic                  det_en;
  } brc_top_regs_t;

  brc_top_regs_t r;
  brc_top_regs_t r_nxt;

  logic            por_s;
  logic            rdy_s;
  logic [NLVL-1:0] bel_s;
  logic            below;
  logic            prot;
  logic            por_hold;
  logic            bor_hold;
  logic            other;
  logic            gate_ok;

  brc_sync2 #(.W(1)) u_sync_por (.pclk(pclk), .presetn(presetn), .d(por_ok_a), .q(por_s)); // RULE19
  brc_sync2 #(.W(1)) u_sync_rdy (.pclk(pclk), .presetn(presetn), .d(bor_rdy_a), .q(rdy_s)); // RULE19
  brc_sync2 #(.W(NLVL)) u_sync_bel (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (bor_below_a),
    .q       (bel_s)
  ); // RULE19

  assign below    = bel_s[r.lvl[LW-1:0]]; // RULE5
  assign prot     = r.det_en & rdy_s; // RULE12
  assign por_hold = ~por_s | prog_mode; // RULE3 RULE4
  assign bor_hold = prot & below & (r.filt == BRC_FILT_W'(BRC_FILT_CYC)); // RULE5 RULE6
  assign other    = (ext_clear_en & ~ext_clear_pin_n) | wdt_timeout | reset_instr
                  | stack_ovf | stack_unf; // RULE1
  always_comb begin
    case (r.mode)
      BRC_MODE_ON, BRC_MODE_NOSLEEP: gate_ok = rdy_s & ~below; // RULE7 RULE15
      default:                       gate_ok = 1'b1; // RULE11 RULE14
    endcase
  end

  always_comb begin
    r_nxt         = r;
    r_nxt.pready  = 1'b0;
    r_nxt.pslverr = 1'b0;
    // One wait state: the answer is prepared in the first access cycle.
    if (psel && penable && !r.pready) begin
      r_nxt.pready  = 1'b1;
      r_nxt.prdata  = 32'h0;
      case (paddr)
        BRC_CFG_OFS: begin
          r_nxt.prdata[BRC_CFG_MODE_LSB +: 2]  = r.mode;
          r_nxt.prdata[BRC_CFG_LEVEL_LSB +: 2] = r.lvl;
          r_nxt.prdata[BRC_CFG_POWER_UP_DELAY_TIMER_LSB +: 2]  = r.powerup_delay_sel;
        end
        BRC_CTRL_OFS: r_nxt.prdata[BRC_CTRL_SWEN_BIT] = r.sw_en;
        BRC_STAT_OFS: begin
          r_nxt.prdata[BRC_STAT_RDY_BIT]   = rdy_s; // RULE12
          r_nxt.prdata[BRC_STAT_FLAGN_BIT] = r.flag_n;
          r_nxt.prdata[BRC_STAT_RUN_BIT]   = r.run;
          r_nxt.prdata[BRC_STAT_RSTN_BIT]  = r.rst_n;
          r_nxt.prdata[BRC_STAT_BELOW_BIT] = below;
        end
        default: r_nxt.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && r.pready && pwrite) begin
      case (paddr)
        BRC_CFG_OFS: begin
          r_nxt.mode  = pwdata[BRC_CFG_MODE_LSB +: 2];
          r_nxt.lvl   = pwdata[BRC_CFG_LEVEL_LSB +: 2];
          r_nxt.powerup_delay_sel = pwdata[BRC_CFG_POWER_UP_DELAY_TIMER_LSB +: 2];
        end
        BRC_CTRL_OFS: begin
          if (r.mode != BRC_MODE_OFF) begin
            r_nxt.sw_en = pwdata[BRC_CTRL_SWEN_BIT]; // RULE14
          end
        end
        BRC_STAT_OFS: begin
          if (pwdata[BRC_STAT_FLAGN_BIT]) begin
            r_nxt.flag_n = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // Detector power follows the mode; sleep only matters in mode 10.
    case (r.mode)
      BRC_MODE_ON:      r_nxt.det_en = 1'b1; // RULE7 RULE8
      BRC_MODE_NOSLEEP: r_nxt.det_en = (r.st != BRC_ST_SLEEP); // RULE9
      BRC_MODE_SW:      r_nxt.det_en = r.sw_en; // RULE10 RULE13
      default:          r_nxt.det_en = 1'b0; // RULE14
    endcase

    // Dip filter: counts consecutive cycles of a protected low supply.
    if (prot && below) begin
      if (r.filt != BRC_FILT_W'(BRC_FILT_CYC)) begin
        r_nxt.filt = r.filt + BRC_FILT_W'(1); // RULE6
      end
    end else begin
      r_nxt.filt = '0;
    end

    if (por_hold) begin
      r_nxt.st = BRC_ST_HOLD; // RULE3 RULE4
    end else if (bor_hold) begin
      r_nxt.st     = BRC_ST_HOLD; // RULE5
      r_nxt.flag_n = 1'b0; // RULE6
    end else if (other && r.st != BRC_ST_HOLD && r.st != BRC_ST_POWER_UP_DELAY_TIMER) begin
      r_nxt.st = BRC_ST_CLR; // RULE1
    end else begin
      case (r.st)
        BRC_ST_HOLD: begin
          case (r.powerup_delay_sel)
            BRC_POWER_UP_DELAY_TIMER_OFF: r_nxt.st = BRC_ST_CLR; // RULE16
            2'h1: r_nxt.cnt = PW'(POWER_UP_DELAY_TIMER_CYC >> 4);
            2'h2: r_nxt.cnt = PW'(POWER_UP_DELAY_TIMER_CYC >> 2);
            default: r_nxt.cnt = PW'(POWER_UP_DELAY_TIMER_CYC); // RULE17
          endcase
          if (r.powerup_delay_sel != BRC_POWER_UP_DELAY_TIMER_OFF) begin
            r_nxt.st = BRC_ST_POWER_UP_DELAY_TIMER; // RULE2 RULE16
          end
        end
        BRC_ST_POWER_UP_DELAY_TIMER: begin
          r_nxt.cnt = r.cnt - PW'(1); // RULE17
          if (r.cnt <= PW'(1)) begin
            r_nxt.st = BRC_ST_CLR;
          end
        end
        BRC_ST_CLR: begin
          if (!other && gate_ok) begin
            r_nxt.st  = BRC_ST_START; // RULE7 RULE11
            r_nxt.cnt = PW'(BRC_START_CYC); // RULE18
          end
        end
        BRC_ST_START: begin
          r_nxt.cnt = r.cnt - PW'(1);
          if (r.cnt <= PW'(1)) begin
            r_nxt.st = BRC_ST_RUN; // RULE18
          end
        end
        BRC_ST_RUN: begin
          if (sleep_mode) begin
            r_nxt.st = BRC_ST_SLEEP;
          end
        end
        BRC_ST_SLEEP: begin
          if (wake_req) begin
            r_nxt.st = (r.mode == BRC_MODE_NOSLEEP) ? BRC_ST_WAKE : BRC_ST_RUN; // RULE8 RULE9
          end
        end
        BRC_ST_WAKE: begin
          if (rdy_s && !below) begin
            r_nxt.st = BRC_ST_RUN; // RULE9
          end
        end
        default: r_nxt.st = BRC_ST_HOLD;
      endcase
    end
    r_nxt.rst_n = (r_nxt.st == BRC_ST_RUN) || (r_nxt.st == BRC_ST_SLEEP)
               || (r_nxt.st == BRC_ST_WAKE); // RULE1
    r_nxt.run   = (r_nxt.st == BRC_ST_RUN);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r        <= '0;
      r.st     <= BRC_ST_HOLD;
      r.mode   <= BRC_MODE_RST;
      r.lvl    <= BRC_LEVEL_RST;
      r.powerup_delay_sel  <= BRC_POWER_UP_DELAY_TIMER_RST;
      r.sw_en  <= BRC_SWEN_RST;
      r.flag_n <= 1'b1;
    end else begin
      r <= r_nxt;
    end
  end

  assign prdata      = r.prdata;
  assign pready      = r.pready;
  assign pslverr     = r.pslverr;
  assign cpu_reset_n = r.rst_n;
  assign cpu_run     = r.run;
  assign bor_det_en  = r.det_en;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_start_entry;
    (r.st == BRC_ST_CLR) ##1 (r.st == BRC_ST_START);
  endsequence
  sequence s_start_wait;
    (r.st == BRC_ST_START && !cpu_run) [*3];
  endsequence

  property p_src;
    (wdt_timeout || reset_instr || stack_ovf) && r.st == BRC_ST_RUN |=> !cpu_reset_n;
  endproperty
  a_src: assert property (p_src) else $error("reset source did not reset core"); // RULE1
  property p_por;
    !por_s |=> !cpu_reset_n && r.st == BRC_ST_HOLD;
  endproperty
  a_por: assert property (p_por) else $error("core left reset below power-on level"); // RULE3
  property p_prog;
    prog_mode ##1 !prog_mode && por_s |-> r.st == BRC_ST_HOLD;
  endproperty
  a_prog: assert property (p_prog) else $error("programming exit not like power-on"); // RULE4
  property p_trip;
    bor_hold && !por_hold |=> !cpu_reset_n && !r.flag_n && r.st == BRC_ST_HOLD;
  endproperty
  a_trip: assert property (p_trip) else $error("brown-out trip missed"); // RULE5 RULE6
  property p_short;
    prot && below && r.filt == '0 && r.st == BRC_ST_RUN && !por_hold && !other
      && !sleep_mode |=> cpu_reset_n;
  endproperty
  a_short: assert property (p_short) else $error("short dip caused reset"); // RULE6
  property p_power_up_delay_timer;
    r.st == BRC_ST_HOLD && !por_hold && !bor_hold |=>
      (r.st == BRC_ST_POWER_UP_DELAY_TIMER) == ($past(r.powerup_delay_sel) != BRC_POWER_UP_DELAY_TIMER_OFF);
  endproperty
  a_power_up_delay_timer: assert property (p_power_up_delay_timer) else $error("power-up delay selection wrong"); // RULE16
  property p_power_up_delay_timer_hold;
    r.st == BRC_ST_POWER_UP_DELAY_TIMER |-> !cpu_reset_n && !cpu_run;
  endproperty
  a_power_up_delay_timer_hold: assert property (p_power_up_delay_timer_hold) else $error("reset released in delay"); // RULE17
  property p_start;
    s_start_entry |-> r.cnt == PW'(BRC_START_CYC) ##0 s_start_wait;
  endproperty
  a_start: assert property (p_start) else $error("start delay wrong"); // RULE18
  property p_rdy_first;
    $rose(r.st == BRC_ST_START) && r.mode == BRC_MODE_ON |-> $past(rdy_s);
  endproperty
  a_rdy_first: assert property (p_rdy_first) else $error("started before ready"); // RULE7 RULE15
  property p_sw;
    r.mode == BRC_MODE_SW |=> bor_det_en == $past(r.sw_en);
  endproperty
  a_sw: assert property (p_sw) else $error("detector not following enable"); // RULE10 RULE13
  property p_off;
    r.mode == BRC_MODE_OFF |=> !bor_det_en;
  endproperty
  a_off: assert property (p_off) else $error("detector on in off mode"); // RULE14
  property p_nosleep;
    r.mode == BRC_MODE_NOSLEEP && r.st == BRC_ST_SLEEP |=> !bor_det_en;
  endproperty
  a_nosleep: assert property (p_nosleep) else $error("detector awake in sleep"); // RULE9
  property p_wake_on;
    r.mode == BRC_MODE_ON && r.st == BRC_ST_SLEEP && wake_req && !por_hold && !bor_hold
      && !other |=> cpu_run;
  endproperty
  a_wake_on: assert property (p_wake_on) else $error("wake-up delayed"); // RULE8
  property p_sw_start;
    r.mode == BRC_MODE_SW && r.st == BRC_ST_CLR && !other && !por_hold && !bor_hold
      |=> r.st == BRC_ST_START;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("software mode start gated"); // RULE11
endmodule : brc_top

// >>> verification/brc_supply_model.sv
// Behavioural model of the analog supply detectors facing the sequencer.
// Assumes the bench sets the supply picture; ready follows detector power.
`timescale 1ns/1ns
module brc_supply_model #(
  parameter int NLVL    = 4,
  parameter int RDY_DLY = 8
) (
  // Clock.
  input  wire logic            pclk,
  // Supply picture from the bench.
  input  wire logic            vdd_on,
  input  wire logic [NLVL-1:0] below,
  // Detector power from the sequencer.
  input  wire logic            bor_det_en,
  // Detector outputs.
  output logic                 por_ok_a,
  output logic [NLVL-1:0]      bor_below_a,
  output logic                 bor_rdy_a
);
  int   cnt = 0;
  // The detector needs time after power-up before its outputs mean anything.
  always @(posedge pclk) begin
    if (!bor_det_en) cnt <= 0;
    else if (cnt < RDY_DLY) cnt <= cnt + 1;
  end
  assign por_ok_a    = vdd_on;
  assign bor_rdy_a   = bor_det_en && (cnt == RDY_DLY);
  // A detector that is not ready reports every level as low, the worst case.
  assign bor_below_a = bor_rdy_a ? below : {NLVL{1'b1}};
endmodule : brc_supply_model

// >>> verification/brownout_reset_control_test.sv
// Self-checking bench for the brown-out and reset sequencer.
// Assumes the supply model beside it and a shortened power-up delay.
`timescale 1ns/1ns
module brownout_reset_control_test;
  import brc_pkg::*;
  localparam int PW = 64;
  typedef struct packed {
    logic [7:0]  a;
    logic        w;
    logic [31:0] d;
    logic [31:0] q;
    logic        e;
  } brc_row_t;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        por_ok_a;
  logic        bor_rdy_a;
  logic [3:0]  bor_below_a;
  logic        vdd_on = 1'b0;
  logic [3:0]  below = 4'h0;
  logic [4:0]  src = 5'h00;
  logic        prog_mode = 1'b0;
  logic        sleep_mode = 1'b0;
  logic        wake_req = 1'b0;
  logic        cpu_reset_n;
  logic        cpu_run;
  logic        bor_det_en;
  logic [31:0] q;
  logic        e;
  int          n_errors = 0;
  int          num_checks = 0;
  int          n;
  brc_row_t    rows [0:7] = '{
    '{8'h00, 1'b0, 32'h0, 32'h33, 1'b0}, '{8'h04, 1'b0, 32'h0, 32'h01, 1'b0},
    '{8'h0c, 1'b0, 32'h0, 32'h00, 1'b1}, '{8'h00, 1'b1, 32'h1, 32'h00, 1'b0},
    '{8'h00, 1'b0, 32'h0, 32'h01, 1'b0}, '{8'h04, 1'b1, 32'h0, 32'h00, 1'b0},
    '{8'h04, 1'b0, 32'h0, 32'h00, 1'b0}, '{8'h08, 1'b0, 32'h0, 32'h1e, 1'b0}};

  always #20 pclk = ~pclk;

  brc_top #(.POWER_UP_DELAY_TIMER_CYC(PW), .NLVL(4)) brc_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .por_ok_a(por_ok_a),
    .bor_below_a(bor_below_a), .bor_rdy_a(bor_rdy_a),
    .ext_clear_pin_n(~src[4]), .ext_clear_en(1'b1), .wdt_timeout(src[0]),
    .reset_instr(src[1]), .stack_ovf(src[2]), .stack_unf(src[3]),
    .prog_mode(prog_mode), .sleep_mode(sleep_mode), .wake_req(wake_req),
    .cpu_reset_n(cpu_reset_n), .cpu_run(cpu_run), .bor_det_en(bor_det_en));

  brc_supply_model #(.NLVL(4), .RDY_DLY(8)) brc_supply_model_inst (
    .pclk(pclk), .vdd_on(vdd_on), .below(below), .bor_det_en(bor_det_en),
    .por_ok_a(por_ok_a), .bor_below_a(bor_below_a), .bor_rdy_a(bor_rdy_a));

  task results;
    if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask : chk

  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      n_errors++;
      results();
    end
  endtask : apb

  // Counts edges until the core may execute; a hang ends the run.
  task wait_run;
    n = 0;
    while (cpu_run !== 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 400) begin
      n_errors++;
      results();
    end
  endtask : wait_run

  task hold(input int c);
    repeat (c) begin
      @(posedge pclk);
      chk(cpu_reset_n, 1'b1);
    end
  endtask : hold

  task doze(input logic en);
    sleep_mode <= 1'b1;
    @(posedge pclk);
    sleep_mode <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(cpu_run, 1'b0);
    chk(cpu_reset_n, 1'b1);
    chk(bor_det_en, en);
    wake_req <= 1'b1;
    @(posedge pclk);
    wake_req <= 1'b0;
    wait_run();
  endtask : doze

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (20) @(posedge pclk);
    chk(cpu_reset_n, 1'b0);
    vdd_on <= 1'b1;
    wait_run();
    chk(n >= PW + 10, 1'b1);
    apb(8'h08, 1'b0, 32'h0);
    chk(q[0], 1'b1);
    for (int i = 0; i < 8; i++) begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      if (!rows[i].w) chk(q, rows[i].q);
      chk(e, rows[i].e);
    end
    chk(bor_det_en, 1'b0);
    apb(8'h00, 1'b1, 32'h0);
    apb(8'h04, 1'b1, 32'h1);
    apb(8'h04, 1'b0, 32'h0);
    chk(q, 32'h0);
    chk(bor_det_en, 1'b0);
    apb(8'h00, 1'b1, 32'h7);
    repeat (20) @(posedge pclk);
    apb(8'h08, 1'b0, 32'h0);
    chk(q[0], 1'b1);
    below <= 4'h1;
    hold(40);
    below <= 4'h2;
    hold(20);
    below <= 4'h0;
    @(posedge pclk);
    below <= 4'h2;
    repeat (40) @(posedge pclk);
    chk(cpu_reset_n, 1'b0);
    below <= 4'h0;
    wait_run();
    apb(8'h08, 1'b0, 32'h0);
    chk(q[1], 1'b0);
    apb(8'h08, 1'b1, 32'h2);
    apb(8'h08, 1'b0, 32'h0);
    chk(q[1], 1'b1);
    apb(8'h00, 1'b1, 32'h7);
    for (int i = 0; i < 5; i++) begin
      src <= 5'h01 << i;
      repeat (20) @(posedge pclk);
      chk(cpu_reset_n, 1'b0);
      src <= 5'h00;
      wait_run();
      chk(n >= 10 && n <= 16, 1'b1);
    end
    apb(8'h00, 1'b1, 32'h33);
    prog_mode <= 1'b1;
    repeat (5) @(posedge pclk);
    chk(cpu_reset_n, 1'b0);
    prog_mode <= 1'b0;
    wait_run();
    chk(n >= PW + 10, 1'b1);
    doze(1'b1);
    chk(n <= 3, 1'b1);
    apb(8'h00, 1'b1, 32'h2);
    doze(1'b0);
    chk(n >= 8, 1'b1);
    apb(8'h00, 1'b1, 32'h1);
    apb(8'h04, 1'b1, 32'h1);
    doze(1'b1);
    // Software mode with the detector off must not gate start-up.
    apb(8'h04, 1'b1, 32'h0);
    src <= 5'h01;
    repeat (4) @(posedge pclk);
    src <= 5'h00;
    wait_run();
    chk(n <= 16, 1'b1);
    // Reset in mid-run restores the configuration and holds the core.
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(cpu_reset_n, 1'b0);
    chk(cpu_run, 1'b0);
    chk(bor_det_en, 1'b0);
    presetn <= 1'b1;
    apb(8'h00, 1'b0, 32'h0);
    chk(q, 32'h33);
    chk(cpu_reset_n, 1'b0);
    results();
  end
endmodule : brownout_reset_control_test
